// *** core/dtp_pwm_unit.v ***
`timescale 1ns/1ps
`include "dtp_regs.vh"

module dtp_pwm_unit (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    // shared external clock pin
    input  wire        extClkPin,
    // first wave pin
    input  wire        wavePin1In,
    output wire        wavePin1Out,
    output wire        wavePin1Oe,
    // second wave pin
    input  wire        wavePin2In,
    output wire        wavePin2Out,
    output wire        wavePin2Oe
);
    localparam IW = `DTP_IDX_W;
    localparam NCH = 2;

    // phase divider
    reg  [1:0] qPhase_q;
    wire       cycleEn;
    wire       halfEn;

    // bus data phase
    reg          dataWr_q;
    reg          dataRd_q;
    reg          dataHit_q;
    reg [IW-1:0] dataIdx_q;
    wire         accept;
    wire [7:0]   wd;
    reg  [7:0]   rdMux;

    // software registers
    reg [7:0] timerCfg_q;
    reg [7:0] timerRun_q;
    reg [7:0] count1_q;
    reg [7:0] count2_q;
    reg [7:0] period1_q;
    reg [7:0] period2_q;
    reg [7:0] irqFlags_q;
    reg [7:0] irqFlags_d;
    reg [7:0] irqEnables_q;
    reg [7:0] portData_q;
    reg [7:0] portDir_q;
    reg       baseSel2_q;

    // write strobes
    wire wrCount1;
    wire wrCount2;
    wire wrPeriod1;
    wire wrPeriod2;
    wire wrFlags;
    wire wrEnables;
    wire wrCfg;
    wire wrRun;
    wire wrPortData;
    wire wrPortDir;
    wire [NCH-1:0] wrDutyHigh;
    wire [NCH-1:0] wrDutyLow;

    // timer control
    wire cascade;
    wire run1;
    wire run2;
    wire extFall;
    wire src1;
    wire src2;
    wire tick1;
    wire tick2;
    wire match16;
    wire roll1;
    wire roll2;

    // channel wiring
    wire [8*NCH-1:0]  chanCount;
    wire [NCH-1:0]    chanRoll;
    wire [10*NCH-1:0] chanDuty;
    wire [NCH-1:0]    chanLevel;
    wire [NCH-1:0]    chanEn;
    wire [NCH-1:0]    pinIn;

    // pin registers
    reg [NCH-1:0] pinSync1_q;
    reg [NCH-1:0] pinSync2_q;
    reg [NCH-1:0] pinOut_q;
    reg [NCH-1:0] pinOe_q;

    // oscillator phase counter; one instruction cycle per wrap
    always @(posedge clk) begin
        if (sys_rst)
            qPhase_q <= 2'h0;
        else
            qPhase_q <= qPhase_q + 2'h1;
    end

    assign cycleEn = (qPhase_q == 2'h3);
    assign halfEn  = qPhase_q[0];

    // ahb-lite: writes zero wait, reads one wait state
    assign accept = hsel & hready & htrans[1];
    assign wd     = hwdata[7:0];

    always @(posedge clk) begin
        if (sys_rst) begin
            dataWr_q  <= 1'b0;
            dataRd_q  <= 1'b0;
            dataHit_q <= 1'b0;
            dataIdx_q <= {IW{1'b0}};
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else begin
            dataWr_q  <= accept & hwrite;
            dataRd_q  <= accept & ~hwrite;
            hreadyout <= ~(accept & ~hwrite);
            hresp     <= 1'b0;
            if (accept) begin
                dataIdx_q <= haddr[IW+1:2];
                dataHit_q <= (haddr[31:IW+2] == {(30-IW){1'b0}});
            end
            if (dataRd_q)
                hrdata <= {24'h00_0000, dataHit_q ? rdMux : 8'h00};
        end
    end

    // register decode
    assign wrCount1   = dataWr_q & dataHit_q & (dataIdx_q == {`DTP_BANK2, `DTP_OFS_TIMER1_COUNT});
    assign wrCount2   = dataWr_q & dataHit_q & (dataIdx_q == {`DTP_BANK2, `DTP_OFS_TIMER2_COUNT});
    assign wrPeriod1  = dataWr_q & dataHit_q & (dataIdx_q == {`DTP_BANK2, `DTP_OFS_TIMER1_PERIOD});
    assign wrPeriod2  = dataWr_q & dataHit_q & (dataIdx_q == {`DTP_BANK2, `DTP_OFS_TIMER2_PERIOD});
    assign wrFlags    = dataWr_q & dataHit_q & (dataIdx_q == {`DTP_BANK1, `DTP_OFS_IRQ_FLAGS});
    assign wrEnables  = dataWr_q & dataHit_q & (dataIdx_q == {`DTP_BANK1, `DTP_OFS_IRQ_ENABLES});
    assign wrCfg      = dataWr_q & dataHit_q & (dataIdx_q == {`DTP_BANK3, `DTP_OFS_TIMER_CFG});
    assign wrRun      = dataWr_q & dataHit_q & (dataIdx_q == {`DTP_BANK3, `DTP_OFS_TIMER_RUN});
    assign wrPortData = dataWr_q & dataHit_q & (dataIdx_q == {`DTP_BANK0, `DTP_OFS_PORT_DATA});
    assign wrPortDir  = dataWr_q & dataHit_q & (dataIdx_q == {`DTP_BANK0, `DTP_OFS_PORT_DIR});
    assign wrDutyHigh[0] = dataWr_q & dataHit_q & (dataIdx_q == {`DTP_BANK3, `DTP_OFS_PWM1_DUTY_HIGH});
    assign wrDutyHigh[1] = dataWr_q & dataHit_q & (dataIdx_q == {`DTP_BANK3, `DTP_OFS_PWM2_DUTY_HIGH});
    assign wrDutyLow[0]  = dataWr_q & dataHit_q & (dataIdx_q == {`DTP_BANK3, `DTP_OFS_PWM1_DUTY_LOW});
    assign wrDutyLow[1]  = dataWr_q & dataHit_q & (dataIdx_q == {`DTP_BANK3, `DTP_OFS_PWM2_DUTY_LOW});

    // read mux; duty registers show the active slave copy
    always @* begin
        rdMux = 8'h00;
        case (dataIdx_q)
            {`DTP_BANK2, `DTP_OFS_TIMER1_COUNT}:   rdMux = count1_q;
            {`DTP_BANK2, `DTP_OFS_TIMER2_COUNT}:   rdMux = count2_q;
            {`DTP_BANK2, `DTP_OFS_TIMER1_PERIOD}:  rdMux = period1_q;
            {`DTP_BANK2, `DTP_OFS_TIMER2_PERIOD}:  rdMux = period2_q;
            {`DTP_BANK1, `DTP_OFS_IRQ_FLAGS}:      rdMux = irqFlags_q;
            {`DTP_BANK1, `DTP_OFS_IRQ_ENABLES}:    rdMux = irqEnables_q;
            {`DTP_BANK3, `DTP_OFS_TIMER_CFG}:      rdMux = timerCfg_q;
            {`DTP_BANK3, `DTP_OFS_TIMER_RUN}:      rdMux = timerRun_q;
            {`DTP_BANK0, `DTP_OFS_PORT_DIR}:       rdMux = portDir_q;
            {`DTP_BANK0, `DTP_OFS_PORT_DATA}: begin
                rdMux = portData_q;
                rdMux[`DTP_PORT_BIT_WAVE1]     = pinSync2_q[0];
                rdMux[`DTP_PORT_BIT_WAVE1 + 1] = pinSync2_q[1];
            end
            {`DTP_BANK3, `DTP_OFS_PWM1_DUTY_HIGH}: rdMux = chanDuty[9:2];
            {`DTP_BANK3, `DTP_OFS_PWM2_DUTY_HIGH}: rdMux = chanDuty[19:12];
            {`DTP_BANK3, `DTP_OFS_PWM1_DUTY_LOW}:  rdMux = {chanDuty[1:0], 6'h00};
            {`DTP_BANK3, `DTP_OFS_PWM2_DUTY_LOW}:  rdMux = {chanDuty[11:10], baseSel2_q, 5'h00};
            default:                               rdMux = 8'h00;
        endcase
    end

    // control registers
    always @(posedge clk) begin
        if (sys_rst) begin
            timerCfg_q   <= `DTP_RST_REG;
            timerRun_q   <= `DTP_RST_REG;
            period1_q    <= `DTP_RST_REG;
            period2_q    <= `DTP_RST_REG;
            irqEnables_q <= `DTP_RST_REG;
            portData_q   <= `DTP_RST_REG;
            portDir_q    <= `DTP_RST_REG;
            baseSel2_q   <= 1'b0;
        end else begin
            if (wrCfg)
                timerCfg_q <= wd;
            if (wrRun)
                timerRun_q <= wd & `DTP_RUN_WR_MASK;
            if (wrPeriod1)
                period1_q <= wd;
            if (wrPeriod2)
                period2_q <= wd;
            if (wrEnables)
                irqEnables_q <= wd;
            if (wrPortData)
                portData_q <= wd;
            if (wrPortDir)
                portDir_q <= wd;
            if (wrDutyLow[1])
                baseSel2_q <= wd[`DTP_BIT_BASE_SEL];
        end
    end

    // external clock pin synchroniser and edge detector
    dtp_ext_sync u_ext (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .pinLevel  (extClkPin),
        .sampleEn  (halfEn),
        .fallPulse (extFall)
    );

    // timer clocking
    assign cascade = timerCfg_q[`DTP_BIT_CASCADE];
    assign run1    = timerRun_q[`DTP_BIT_RUN1];
    assign run2    = timerRun_q[`DTP_BIT_RUN2];
    assign src1    = timerCfg_q[`DTP_BIT_CS1] ? extFall : cycleEn;
    assign src2    = timerCfg_q[`DTP_BIT_CS2] ? extFall : cycleEn;
    assign tick1   = run1 & src1;
    assign tick2   = run2 & src2 & ~cascade;
    assign match16 = ({count2_q, count1_q} == {period2_q, period1_q});
    assign roll1   = tick1 & (cascade ? (run2 & match16) : (count1_q == period1_q));
    assign roll2   = tick2 & (count2_q == period2_q);

    // low counter
    always @(posedge clk) begin
        if (sys_rst)
            count1_q <= `DTP_RST_REG;
        else if (wrCount1)
            count1_q <= wd;
        else if (roll1)
            count1_q <= 8'h00;
        else if (tick1)
            count1_q <= count1_q + 8'h01;
    end

    // high counter: own timer, or upper byte in cascade
    always @(posedge clk) begin
        if (sys_rst)
            count2_q <= `DTP_RST_REG;
        else if (wrCount2)
            count2_q <= wd;
        else if (cascade) begin
            if (roll1)
                count2_q <= 8'h00;
            else if (tick1 & run2 & (count1_q == 8'hFF))
                count2_q <= count2_q + 8'h01;
        end else if (roll2)
            count2_q <= 8'h00;
        else if (tick2)
            count2_q <= count2_q + 8'h01;
    end

    // flags: a hardware set wins over a software write
    always @* begin
        irqFlags_d = wrFlags ? wd : irqFlags_q;
        if (roll1)
            irqFlags_d[`DTP_BIT_FLAG1] = 1'b1;
        if (roll2)
            irqFlags_d[`DTP_BIT_FLAG2] = 1'b1;
    end

    always @(posedge clk) begin
        if (sys_rst)
            irqFlags_q <= `DTP_RST_IRQ_FLAGS;
        else
            irqFlags_q <= irqFlags_d;
    end

    // time-base routing per channel
    assign chanCount[7:0]  = count1_q;
    assign chanRoll[0]     = roll1;
    assign chanCount[15:8] = baseSel2_q ? count2_q : count1_q;
    assign chanRoll[1]     = baseSel2_q ? roll2 : roll1;
    assign chanEn[0]       = timerRun_q[`DTP_BIT_PWM1_EN];
    assign chanEn[1]       = timerRun_q[`DTP_BIT_PWM2_EN];
    assign pinIn           = {wavePin2In, wavePin1In};

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : gChan
            dtp_pwm_chan #(
                .CW (8),
                .SW (`DTP_SUB_W)
            ) u_chan (
                .clk       (clk),
                .sys_rst   (sys_rst),
                .wrHigh    (wrDutyHigh[g]),
                .wrLow     (wrDutyLow[g]),
                .wrData    (wd),
                .roll      (chanRoll[g]),
                .count     (chanCount[8*g+7:8*g]),
                .subPhase  (qPhase_q),
                .slaveDuty (chanDuty[10*g+9:10*g]),
                .level     (chanLevel[g])
            );

            // pin mux: enabled wave forces drive; else port latch and direction
            always @(posedge clk) begin
                if (sys_rst) begin
                    pinSync1_q[g] <= 1'b0;
                    pinSync2_q[g] <= 1'b0;
                    pinOut_q[g]   <= 1'b0;
                    pinOe_q[g]    <= 1'b0;
                end else begin
                    pinSync1_q[g] <= pinIn[g];
                    pinSync2_q[g] <= pinSync1_q[g];
                    if (chanEn[g]) begin
                        pinOut_q[g] <= chanLevel[g];
                        pinOe_q[g]  <= 1'b1;
                    end else begin
                        pinOut_q[g] <= portData_q[`DTP_PORT_BIT_WAVE1 + g];
                        pinOe_q[g]  <= ~portDir_q[`DTP_PORT_BIT_WAVE1 + g];
                    end
                end
            end
        end
    endgenerate

    assign wavePin1Out = pinOut_q[0];
    assign wavePin1Oe  = pinOe_q[0];
    assign wavePin2Out = pinOut_q[1];
    assign wavePin2Oe  = pinOe_q[1];
endmodule

// *** core/dtp_regs.vh ***
`ifndef DTP_REGS_VH
`define DTP_REGS_VH

// register index = {bank, offset}; byte address = 4 * index
`define DTP_BANK0              2'd0
`define DTP_BANK1              2'd1
`define DTP_BANK2              2'd2
`define DTP_BANK3              2'd3
`define DTP_IDX_W              7

// printed offsets
`define DTP_OFS_TIMER1_COUNT   5'h10
`define DTP_OFS_TIMER2_COUNT   5'h11
`define DTP_OFS_TIMER1_PERIOD  5'h14
`define DTP_OFS_TIMER2_PERIOD  5'h15
`define DTP_OFS_IRQ_FLAGS      5'h16
`define DTP_OFS_IRQ_ENABLES    5'h17
`define DTP_OFS_PWM1_DUTY_LOW  5'h10
`define DTP_OFS_PWM2_DUTY_LOW  5'h11
`define DTP_OFS_PWM1_DUTY_HIGH 5'h12
`define DTP_OFS_PWM2_DUTY_HIGH 5'h13
`define DTP_OFS_TIMER_CFG      5'h16
`define DTP_OFS_TIMER_RUN      5'h17
// port pin registers
`define DTP_OFS_PORT_DATA      5'h01
`define DTP_OFS_PORT_DIR       5'h02

// timer configuration fields
`define DTP_BIT_CS1            0
`define DTP_BIT_CS2            1
`define DTP_BIT_CASCADE        3
// run control fields
`define DTP_BIT_RUN1           0
`define DTP_BIT_RUN2           1
`define DTP_BIT_PWM1_EN        4
`define DTP_BIT_PWM2_EN        5
`define DTP_RUN_WR_MASK        8'h3F
// flag fields
`define DTP_BIT_FLAG1          4
`define DTP_BIT_FLAG2          5
// duty low fields
`define DTP_BIT_BASE_SEL       5
`define DTP_DL_MSB             7
// port bit of the first wave pin
`define DTP_PORT_BIT_WAVE1     2

// reset values
`define DTP_RST_IRQ_FLAGS      8'h02
`define DTP_RST_REG            8'h00

// timing: one instruction cycle is four oscillator phases
`define DTP_PHASES_PER_CYCLE   4
`define DTP_SUB_W              2

`endif

// *** core/dtp_ext_sync.v ***
`timescale 1ns/1ps
`include "dtp_regs.vh"

// synchronises the shared clock pin and reports falling edges
module dtp_ext_sync (
    // clock and reset
    input  wire clk,
    input  wire sys_rst,
    // pin and sample strobe
    input  wire pinLevel,
    input  wire sampleEn,
    // result
    output reg  fallPulse
);
    reg sync1_q;
    reg sync2_q;
    reg sample_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            sync1_q   <= 1'b1;
            sync2_q   <= 1'b1;
            sample_q  <= 1'b1;
            fallPulse <= 1'b0;
        end else begin
            sync1_q   <= pinLevel;
            sync2_q   <= sync1_q;
            fallPulse <= 1'b0;
            if (sampleEn) begin
                sample_q  <= sync2_q;
                fallPulse <= sample_q & ~sync2_q;
            end
        end
    end
endmodule

// *** core/dtp_pwm_chan.v ***
`timescale 1ns/1ps
`include "dtp_regs.vh"

// one wave channel: double-buffered duty and compare
module dtp_pwm_chan #(
    parameter CW = 8,
    parameter SW = `DTP_SUB_W
) (
    // clock and reset
    input  wire               clk,
    input  wire               sys_rst,
    // duty writes
    input  wire               wrHigh,
    input  wire               wrLow,
    input  wire [7:0]         wrData,
    // time-base
    input  wire               roll,
    input  wire [CW-1:0]      count,
    input  wire [SW-1:0]      subPhase,
    // results
    output reg  [CW+SW-1:0]   slaveDuty,
    output reg                level
);
    reg [CW-1:0] masterHi_q;
    reg [SW-1:0] masterLo_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            masterHi_q <= {CW{1'b0}};
            masterLo_q <= {SW{1'b0}};
            slaveDuty  <= {(CW+SW){1'b0}};
            level      <= 1'b0;
        end else begin
            if (wrHigh)
                masterHi_q <= wrData[CW-1:0];
            if (wrLow)
                masterLo_q <= wrData[`DTP_DL_MSB -: SW];
            if (roll)
                slaveDuty <= {masterHi_q, masterLo_q};
            // high while count is below duty; zero duty never goes high
            level <= ({count, subPhase} < slaveDuty);
        end
    end
endmodule

// *** verif/dtp_pwm_unit_sva.sv ***
`timescale 1ns/1ps
module dtp_pwm_unit_chk (
    // clock and reset
    input wire        clk,
    input wire        sys_rst,
    // bus
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hwdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    // pins
    input wire        wavePin1Out,
    input wire        wavePin1Oe,
    input wire        wavePin2Oe
);
    reg        wrPend_q;
    reg  [6:0] wrIdx_q;
    reg  [1:0] en_q;
    reg  [1:0] dir_q;
    reg        dat1_q;
    wire       take = hsel && hready && htrans[1];
    wire       drv1 = en_q[0] || !dir_q[0];
    wire       drv2 = en_q[1] || !dir_q[1];
    // shadow of enable, direction and port data writes
    always @(posedge clk) begin
        if (sys_rst) begin
            wrPend_q <= 1'b0;
            wrIdx_q  <= 7'h00;
            en_q     <= 2'h0;
            dir_q    <= 2'h0;
            dat1_q   <= 1'b0;
        end else begin
            wrPend_q <= take && hwrite;
            if (take)
                wrIdx_q <= haddr[8:2];
            if (wrPend_q && wrIdx_q == 7'h77)
                en_q <= hwdata[5:4];
            if (wrPend_q && wrIdx_q == 7'h02)
                dir_q <= hwdata[3:2];
            if (wrPend_q && wrIdx_q == 7'h01)
                dat1_q <= hwdata[2];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_okay;
        !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("error response");
    property p_rd_wait;
        take && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_nowait;
        take && hwrite |=> hreadyout;
    endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_rd_stand;
        $changed(hrdata) |-> $rose(hreadyout);
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
    property p_rd_upper;
        $rose(hreadyout) |-> hrdata[31:8] == 24'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    property p_pin1_oe;
        !$past(sys_rst) && drv1 == $past(drv1) |-> wavePin1Oe == drv1;
    endproperty
    a_pin1_oe: assert property (p_pin1_oe) else $error("pin1 enable wrong");
    property p_pin2_oe;
        !$past(sys_rst) && drv2 == $past(drv2) |-> wavePin2Oe == drv2;
    endproperty
    a_pin2_oe: assert property (p_pin2_oe) else $error("pin2 enable wrong");
    property p_pin1_dat;
        !$past(sys_rst) && !en_q[0] && !$past(en_q[0]) && dat1_q == $past(dat1_q) |-> wavePin1Out == dat1_q;
    endproperty
    a_pin1_dat: assert property (p_pin1_dat) else $error("pin1 port level wrong");
endmodule

bind dtp_pwm_unit dtp_pwm_unit_chk chk_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .wavePin1Out(wavePin1Out), .wavePin1Oe(wavePin1Oe),
    .wavePin2Oe(wavePin2Oe));

// *** verif/dtp_pin_model.sv ***
`timescale 1ns/1ps
module dtp_pin_model (
    // wave pins from the block
    input  wire  wavePin1Out,
    input  wire  wavePin1Oe,
    input  wire  wavePin2Out,
    input  wire  wavePin2Oe,
    // levels seen by the block
    output logic extClkPin,
    output wire  wavePin1In,
    output wire  wavePin2In
);
    logic last1 = 1'b0;
    logic last2 = 1'b0;
    initial extClkPin = 1'b1;
    // a released pin shows the inverse of its last driven level
    always @(wavePin1Out or wavePin1Oe) if (wavePin1Oe) last1 = wavePin1Out;
    always @(wavePin2Out or wavePin2Oe) if (wavePin2Oe) last2 = wavePin2Out;
    assign wavePin1In = wavePin1Oe ? wavePin1Out : ~last1;
    assign wavePin2In = wavePin2Oe ? wavePin2Out : ~last2;
    // n falling edges, clock stands high between bursts
    task automatic burst(input int n);
        repeat (n) begin
            #211 extClkPin = 1'b0;
            #193 extClkPin = 1'b1;
        end
    endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
    // register index = bank * 32 + offset
    localparam logic [6:0] CFG = 7'h76, RUN = 7'h77, FLG = 7'h36, IEN = 7'h37, C1 = 7'h50, C2 = 7'h51,
        P1 = 7'h54, P2 = 7'h55, DL1 = 7'h70, DL2 = 7'h71, DH1 = 7'h72, DH2 = 7'h73, DIR = 7'h02, PDAT = 7'h01;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rdq;
    wire         hreadyout, hresp, extClkPin, wavePin1In, wavePin2In;
    wire         wavePin1Out, wavePin1Oe, wavePin2Out, wavePin2Oe;
    wire  [31:0] hrdata;
    int          miscompares = 0;
    int          n_tests = 0;
    int          cyc = 0;
    dtp_pwm_unit dut_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .extClkPin(extClkPin), .wavePin1In(wavePin1In),
        .wavePin1Out(wavePin1Out), .wavePin1Oe(wavePin1Oe), .wavePin2In(wavePin2In),
        .wavePin2Out(wavePin2Out), .wavePin2Oe(wavePin2Oe));
    dtp_pin_model pm_u (.wavePin1Out(wavePin1Out), .wavePin1Oe(wavePin1Oe), .wavePin2Out(wavePin2Out),
        .wavePin2Oe(wavePin2Oe), .extClkPin(extClkPin), .wavePin1In(wavePin1In), .wavePin2In(wavePin2In));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("miscompares %0d, n_tests %0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // wait for hready high at a rising edge, take read data at that edge
    task automatic rdy();
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdq = hrdata;
    endtask
    task automatic bus(input logic w, input logic [6:0] i, input logic [7:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {23'h0, i, 2'h0};
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        rdy();
    endtask
    task automatic wrl(input logic [14:0] l[$]);
        foreach (l[k]) bus(1'b1, l[k][14:8], l[k][7:0]);
    endtask
    task automatic rd(input logic [6:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h00);
        check(rdq, {24'h0, e});
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // high samples of a wave pin over n clocks
    task automatic hic(input logic ch, input int n, output int h);
        h = 0;
        repeat (n) begin
            @(negedge clk);
            h += int'((ch ? wavePin2Out : wavePin1Out) === 1'b1);
        end
    endtask
    task automatic t_reset();
        rd(FLG, 8'h02);
        rd(RUN, 8'h00);
        rd(CFG, 8'h00);
        rd(IEN, 8'h00);
        wrl('{{IEN, 8'h30}, {7'h05, 8'hAA}});
        rd(IEN, 8'h30);
        rd(7'h05, 8'h00);
    endtask
    task automatic t_pwm1();
        int h;
        wrl('{{P1, 8'h03}, {DH1, 8'h01}, {DL1, 8'h80}});
        rd(DH1, 8'h00);
        wrl('{{RUN, 8'h11}});
        waitc(40);
        hic(1'b0, 32, h);
        check(h, 12);
        rd(DH1, 8'h01);
        rd(DL1, 8'h80);
        rd(FLG, 8'h12);
        wrl('{{RUN, 8'h10}, {FLG, 8'h02}, {C1, 8'h02}});
        waitc(20);
        rd(FLG, 8'h02);
        rd(C1, 8'h02);
    endtask
    task automatic t_pwm2();
        logic [15:0] tbl[4] = '{16'h0020, 16'h07E0, 16'h0720, 16'h0820};
        int          exp[4] = '{0, 62, 56, 64};
        int          h;
        wrl('{{DIR, 8'h0C}, {P2, 8'h07}, {RUN, 8'h23}});
        repeat (2) @(negedge clk);
        check(wavePin2Oe, 1'b1);
        check(wavePin1Oe, 1'b0);
        foreach (tbl[k]) begin
            wrl('{{DH2, tbl[k][15:8]}, {DL2, tbl[k][7:0]}});
            waitc(70);
            hic(1'b1, 64, h);
            check(h, exp[k]);
        end
        wrl('{{RUN, 8'h00}, {DIR, 8'h00}, {PDAT, 8'h04}});
        repeat (2) @(negedge clk);
        check({wavePin1Oe, wavePin1Out, wavePin2Out}, 3'h6);
    endtask
    task automatic t_cascade();
        wrl('{{CFG, 8'h0A}, {P1, 8'hFF}, {P2, 8'hFF}, {C1, 8'hFD}, {C2, 8'h03}, {RUN, 8'h03}});
        waitc(40);
        wrl('{{RUN, 8'h00}});
        rd(C2, 8'h04);
        wrl('{{C1, 8'hFD}, {C2, 8'h03}, {RUN, 8'h01}});
        waitc(40);
        wrl('{{RUN, 8'h00}});
        rd(C2, 8'h03);
        wrl('{{P2, 8'h03}, {FLG, 8'h02}, {C1, 8'hFD}, {C2, 8'h03}, {RUN, 8'h03}});
        waitc(40);
        wrl('{{RUN, 8'h00}});
        rd(FLG, 8'h12);
        rd(C2, 8'h00);
    endtask
    // both 8-bit timers on the shared pin
    task automatic t_ext();
        wrl('{{CFG, 8'h03}, {P1, 8'hFF}, {P2, 8'hFF}, {C1, 8'h00}, {C2, 8'h00}, {RUN, 8'h03}});
        pm_u.burst(5);
        waitc(10);
        wrl('{{RUN, 8'h00}});
        rd(C1, 8'h05);
        rd(C2, 8'h05);
    endtask
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        waitc(12);
        sys_rst <= 1'b0;
        t_reset();
        t_pwm1();
        t_pwm2();
        t_cascade();
        t_ext();
        stop_test();
    end
endmodule
